// ==== logic/ppsw_regs.svh ====
// Register offsets, field positions, reset values and counts for the power-state and wake block.
// Assumes a 32-bit classic Wishbone slave with word-aligned byte addresses.
`ifndef PPSW_REGS_SVH
`define PPSW_REGS_SVH
`define PPSW_ADR_POWER_CTRL 8'h00
`define PPSW_ADR_CMD 8'h04
`define PPSW_ADR_WAKE_CTRL 8'h08
`define PPSW_ADR_RX_FILTER 8'h0c
`define PPSW_ADR_STATUS 8'h10
`define PPSW_ADR_PATTERN 8'h14
`define PPSW_ADR_PAT_CLEAR 8'h18
`define PPSW_PS_LO 0
`define PPSW_PME_EN_BIT 8
`define PPSW_PME_STAT_BIT 15
`define PPSW_CMD_IO_BIT 0
`define PPSW_CMD_MEM_BIT 1
`define PPSW_CMD_MST_BIT 2
`define PPSW_WK_LINK_EN 0
`define PPSW_WK_MAGIC_EN 1
`define PPSW_WK_PAT_EN 2
`define PPSW_WK_LINK_SEEN 4
`define PPSW_WK_MAGIC_SEEN 5
`define PPSW_WK_PAT_SEEN 6
`define PPSW_CFG_D1_BIT 9
`define PPSW_CFG_D2_BIT 10
`define PPSW_PAT_DEPTH 256
`define PPSW_PAT_AW 8
`define PPSW_PAT_END 8'h00
`define PPSW_CRC_INIT 32'hffffffff
`define PPSW_CRC_POLY 32'hedb88320
`define PPSW_CRC_BYTES 3'h4
`define PPSW_ZERO32 32'h00000000
`endif

// ==== logic/ppsw_pkg.sv ====
// Types shared by the power-state and wake block.
// Assumes nothing beyond the register header.
package ppsw_pkg;
	typedef enum logic [1:0] {PPSW_D0, PPSW_D1, PPSW_D2, PPSW_D3} ppsw_pstate_t;
	typedef struct packed {
		logic io;
		logic mem;
		logic cfg;
		logic master;
	} ppsw_access_t;
	typedef struct packed {
		logic valid;
		logic sof;
		logic eof;
		logic [7:0] data;
	} ppsw_rx_byte_t;
endpackage

// ==== logic/ppsw_pat_mem.sv ====
// Byte memory holding the wake patterns; read data comes from a register.
// Assumes one write and one read port on a single clock.
`timescale 1ns/10ps
`include "ppsw_regs.svh"
module ppsw_pat_mem
(
	input wire logic clk_i,
	input wire logic we_i,
	input wire logic [7:0] waddr_i,
	input wire logic [7:0] wdata_i,
	input wire logic [7:0] raddr_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [0:`PPSW_PAT_DEPTH-1];
	always_ff @(posedge clk_i)
	begin
		if (we_i)
			mem[waddr_i] <= wdata_i;
		rdata_o <= mem[raddr_i];
	end
endmodule

// ==== logic/ppsw_crc.sv ====
// Byte-wide Ethernet CRC-32 step, reflected form, combinational.
// Assumes the caller holds the running remainder.
`timescale 1ns/10ps
`include "ppsw_regs.svh"
module ppsw_crc
(
	input wire logic [31:0] crc_i,
	input wire logic [7:0] data_i,
	output logic [31:0] crc_o
);
	always_comb
	begin
		logic [31:0] c;
		c = crc_i ^ {24'h000000, data_i};
		for (int i = 0; i < 8; i++)
			c = c[0] ? ((c >> 1) ^ `PPSW_CRC_POLY) : (c >> 1);
		crc_o = c;
	end
endmodule

// ==== logic/ppsw_top.sv ====
// Power-state manager and wake-event detector with a Wishbone register slave.
// Assumes received bytes arrive with frame markers and an address-filter verdict at frame end.
// Notes on behaviour
// - Reset or exit from deep sleep gives uninitialised D0 answering configuration only.
// - With decode and master enables set, D0 answers I/O, memory, config and masters.
// - In D0 the wake event pin is never asserted after the first cycle.
// - Light sleep only when its EEPROM support bit is set; return is immediate.
// - Partial sleep only when its EEPROM support bit is set; returns faster than D3.
// - In sleep states only configuration accesses are answered.
// - In sleep states wake and link events are detected and signalled.
// - Entering deep sleep clears PME enable, command bits and receive filter; wake enables and patterns are kept.
// - Pattern, magic-frame and link wakes each pass only when enabled.
// - Pattern enable has no effect in D0.
// - An enabled pattern match sets its seen bit and, with PME enable set, the wake pin.
// - Each frame is checked against the first stored pattern and must pass address filtering.
// - A pattern is skip/include byte pairs, an end marker and four CRC bytes.
// - Each pair skips frame bytes then feeds bytes into the CRC.
// - Byte 00 ends a pattern; the next four bytes are the expected CRC.
// - Ethernet polynomial CRC equal to the stored value declares a match.
`timescale 1ns/10ps
`include "ppsw_regs.svh"
module ppsw_top
(
	input wire logic clk_i,
	input wire logic rst_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	input wire logic wb_we_i,
	input wire logic [7:0] wb_adr_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	output logic wb_ack_o,
	input wire logic [15:0] eeprom_config_word_i,
	input wire ppsw_pkg::ppsw_rx_byte_t rx_i,
	input wire logic rx_addr_pass_i,
	input wire logic magic_frame_i,
	input wire logic link_change_i,
	output ppsw_pkg::ppsw_access_t access_o,
	output logic wake_event_out_n_o,
	output logic config_initialised_o
);
	// ==================== Register slave ====================
	ppsw_pkg::ppsw_pstate_t power_state_field;
	logic pme_enable;
	logic pme_status;
	logic io_decode_enable;
	logic mem_decode_enable;
	logic master_enable;
	logic [2:0] wake_enables;
	logic link_seen;
	logic magic_seen;
	logic pattern_wake_seen;
	logic [3:0] rx_filter_register;
	logic [7:0] pat_wptr;
	logic cfg_init;
	logic [31:0] next_rdata;
	wire req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
	wire wr = req & wb_we_i;
	wire wr_lo = wr & wb_sel_i[0];
	wire wr_hi = wr & wb_sel_i[1];
	wire wr_pwr = wr & (wb_adr_i == `PPSW_ADR_POWER_CTRL);
	wire wr_cmd = wr_lo & (wb_adr_i == `PPSW_ADR_CMD);
	wire wr_wake = wr_lo & (wb_adr_i == `PPSW_ADR_WAKE_CTRL);
	wire wr_filt = wr_lo & (wb_adr_i == `PPSW_ADR_RX_FILTER);
	wire wr_pat = wr_lo & (wb_adr_i == `PPSW_ADR_PATTERN);
	wire wr_pclr = wr_lo & (wb_adr_i == `PPSW_ADR_PAT_CLEAR);
	wire [1:0] req_state = wb_dat_i[`PPSW_PS_LO+1:`PPSW_PS_LO];
	wire d1_ok = eeprom_config_word_i[`PPSW_CFG_D1_BIT];
	wire d2_ok = eeprom_config_word_i[`PPSW_CFG_D2_BIT];
	// Unsupported light or partial sleep requests are ignored, leaving the state unchanged.
	wire state_ok = (req_state != 2'h1 || d1_ok) && (req_state != 2'h2 || d2_ok);
	wire ps_write = wr_pwr & wb_sel_i[0] & state_ok;
	wire enter_d3 = ps_write & (req_state == 2'h3) & (power_state_field != ppsw_pkg::PPSW_D3);
	wire leave_d3 = ps_write & (req_state == 2'h0) & (power_state_field == ppsw_pkg::PPSW_D3);
	wire asleep = power_state_field != ppsw_pkg::PPSW_D0;
	// ==================== Wake sources ====================
	logic pat_match;
	wire pat_hit = pat_match & asleep & wake_enables[`PPSW_WK_PAT_EN];
	wire magic_hit = magic_frame_i & asleep & wake_enables[`PPSW_WK_MAGIC_EN];
	wire link_hit = link_change_i & asleep & wake_enables[`PPSW_WK_LINK_EN];
	wire any_hit = pat_hit | magic_hit | link_hit;
	wire clr_pme = wr_hi & wr_pwr & wb_dat_i[`PPSW_PME_STAT_BIT];
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			power_state_field <= ppsw_pkg::PPSW_D0;
		else if (ps_write)
			power_state_field <= ppsw_pkg::ppsw_pstate_t'(req_state);
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i || enter_d3)
		begin
			pme_enable <= 1'b0;
			io_decode_enable <= 1'b0;
			mem_decode_enable <= 1'b0;
			master_enable <= 1'b0;
			rx_filter_register <= 4'h0;
			cfg_init <= 1'b0;
		end
		else
		begin
			if (wr_hi && wr_pwr)
				pme_enable <= wb_dat_i[`PPSW_PME_EN_BIT];
			if (wr_cmd)
			begin
				io_decode_enable <= wb_dat_i[`PPSW_CMD_IO_BIT];
				mem_decode_enable <= wb_dat_i[`PPSW_CMD_MEM_BIT];
				master_enable <= wb_dat_i[`PPSW_CMD_MST_BIT];
				cfg_init <= 1'b1;
			end
			if (wr_filt)
				rx_filter_register <= wb_dat_i[3:0];
		end
	end
	// Event flags: the hardware set wins over a software clear in the same cycle.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wake_enables <= 3'h0;
			link_seen <= 1'b0;
			magic_seen <= 1'b0;
			pattern_wake_seen <= 1'b0;
			pme_status <= 1'b0;
		end
		else
		begin
			if (wr_wake)
				wake_enables <= wb_dat_i[`PPSW_WK_PAT_EN:`PPSW_WK_LINK_EN];
			link_seen <= link_hit | (link_seen & ~(wr_wake & wb_dat_i[`PPSW_WK_LINK_SEEN]));
			magic_seen <= magic_hit | (magic_seen & ~(wr_wake & wb_dat_i[`PPSW_WK_MAGIC_SEEN]));
			pattern_wake_seen <= pat_hit
				| (pattern_wake_seen & ~(wr_wake & wb_dat_i[`PPSW_WK_PAT_SEEN]));
			pme_status <= any_hit | (pme_status & ~clr_pme);
		end
	end
	// The pin follows status and enable a cycle later, and is forced off from the second cycle of D0.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			wake_event_out_n_o <= 1'b1;
		else
			wake_event_out_n_o <= ~(pme_status & pme_enable & asleep);
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			access_o <= '0;
		else
		begin
			access_o.cfg <= 1'b1;
			access_o.io <= ~asleep & io_decode_enable;
			access_o.mem <= ~asleep & mem_decode_enable;
			access_o.master <= ~asleep & master_enable;
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (rst_i || leave_d3)
			config_initialised_o <= 1'b0;
		else
			config_initialised_o <= cfg_init;
	end
	always_comb
	begin
		unique case (wb_adr_i)
			`PPSW_ADR_POWER_CTRL:
				next_rdata = {16'h0000, pme_status, 6'h00, pme_enable, 6'h00, power_state_field};
			`PPSW_ADR_CMD:
				next_rdata = {29'h0, master_enable, mem_decode_enable, io_decode_enable};
			`PPSW_ADR_WAKE_CTRL:
				next_rdata = {25'h0, pattern_wake_seen, magic_seen, link_seen, 1'b0, wake_enables};
			`PPSW_ADR_RX_FILTER:
				next_rdata = {28'h0, rx_filter_register};
			`PPSW_ADR_STATUS:
				next_rdata = {23'h0, cfg_init, pat_wptr};
			default:
				next_rdata = `PPSW_ZERO32;
		endcase
	end
	// Every address is answered in the cycle after the request; unmapped reads give zero.
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			wb_ack_o <= 1'b0;
			wb_dat_o <= `PPSW_ZERO32;
		end
		else
		begin
			wb_ack_o <= req;
			wb_dat_o <= req ? next_rdata : `PPSW_ZERO32;
		end
	end
	// ==================== Pattern store ====================
	always_ff @(posedge clk_i)
	begin
		if (rst_i || wr_pclr)
			pat_wptr <= 8'h00;
		else if (wr_pat)
			pat_wptr <= pat_wptr + 8'h01;
	end
	// ==================== Pattern matcher ====================
	// Only the first stored pattern is evaluated per frame, to keep one CRC engine.
	// Received bytes must be spaced by at least two idle cycles while a frame is walked.
	typedef enum logic [2:0] {M_IDLE, M_FETCH, M_SKIP, M_TAKE, M_CRC, M_DONE} ppsw_mstate_t;
	ppsw_mstate_t mstate;
	logic [7:0] raddr;
	logic [7:0] rbyte;
	logic [7:0] count;
	logic [31:0] crc;
	logic [31:0] expect_crc;
	logic [2:0] crc_n;
	logic [31:0] next_crc;
	logic fetch_wait;
	logic [7:0] pend;
	logic eof_seen;
	logic eof_pass;
	wire rxb = rx_i.valid & asleep;
	ppsw_pat_mem u_mem
	(
		.clk_i(clk_i),
		.we_i(wr_pat),
		.waddr_i(pat_wptr),
		.wdata_i(wb_dat_i[7:0]),
		.raddr_i(raddr),
		.rdata_o(rbyte)
	);
	ppsw_crc u_crc
	(
		.crc_i(crc),
		.data_i(rx_i.data),
		.crc_o(next_crc)
	);
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			mstate <= M_IDLE;
			raddr <= 8'h00;
			count <= 8'h00;
			crc <= `PPSW_CRC_INIT;
			expect_crc <= `PPSW_ZERO32;
			crc_n <= 3'h0;
			fetch_wait <= 1'b0;
			pat_match <= 1'b0;
			pend <= 8'h00;
			eof_seen <= 1'b0;
			eof_pass <= 1'b0;
		end
		else
		begin
			pat_match <= 1'b0;
			// The frame end is latched so that the expected CRC may still be fetched after it.
			if (rxb && rx_i.eof)
			begin
				eof_seen <= 1'b1;
				eof_pass <= rx_addr_pass_i;
			end
			if (rxb && rx_i.sof)
			begin
				mstate <= M_FETCH;
				raddr <= 8'h00;
				crc <= `PPSW_CRC_INIT;
				crc_n <= 3'h0;
				fetch_wait <= 1'b1;
				pend <= 8'h01;
				eof_seen <= rx_i.eof;
			end
			else
			begin
				unique case (mstate)
					M_IDLE:
						mstate <= M_IDLE;
					M_FETCH:
						if (fetch_wait)
							fetch_wait <= 1'b0;
						else if (rbyte == `PPSW_PAT_END)
						begin
							mstate <= M_CRC;
							raddr <= raddr + 8'h01;
							fetch_wait <= 1'b1;
						end
						else if (eof_seen)
							mstate <= M_IDLE;
						else
						begin
							// The first frame byte went by while the skip count was fetched.
							count <= rbyte - pend;
							pend <= 8'h00;
							mstate <= M_SKIP;
							raddr <= raddr + 8'h01;
							fetch_wait <= 1'b1;
						end
					M_SKIP:
						if (eof_seen && count != 8'h00)
							mstate <= M_IDLE;
						else if (fetch_wait)
						begin
							fetch_wait <= 1'b0;
							if (rxb && count != 8'h00)
								count <= count - 8'h01;
						end
						else if (count == 8'h00)
						begin
							count <= rbyte;
							mstate <= M_TAKE;
							raddr <= raddr + 8'h01;
						end
						else if (rxb)
							count <= count - 8'h01;
					M_TAKE:
						if (count == 8'h00)
						begin
							mstate <= M_FETCH;
							fetch_wait <= 1'b1;
						end
						else if (eof_seen)
							mstate <= M_IDLE;
						else if (rxb)
						begin
							crc <= next_crc;
							count <= count - 8'h01;
						end
					M_CRC:
						if (fetch_wait)
							fetch_wait <= 1'b0;
						else if (crc_n == `PPSW_CRC_BYTES)
							mstate <= M_DONE;
						else
						begin
							expect_crc <= {rbyte, expect_crc[31:8]};
							crc_n <= crc_n + 3'h1;
							raddr <= raddr + 8'h01;
							fetch_wait <= 1'b1;
						end
					M_DONE:
						if (eof_seen)
						begin
							pat_match <= eof_pass & (~crc == expect_crc);
							mstate <= M_IDLE;
						end
				endcase
			end
		end
	end
	// ==================== Checks ====================
	a_no_wake_d0: assert property (@(posedge clk_i) disable iff (rst_i)
		(power_state_field == ppsw_pkg::PPSW_D0) |=> wake_event_out_n_o)
		else $error("wake pin asserted in D0");
	a_sleep_no_io: assert property (@(posedge clk_i) disable iff (rst_i)
		asleep |=> !access_o.io && !access_o.mem)
		else $error("I/O or memory answered while asleep");
	a_d3_clears_cfg: assert property (@(posedge clk_i) disable iff (rst_i)
		enter_d3 |=> !io_decode_enable && !pme_enable && !cfg_init)
		else $error("configuration survived deep sleep entry");
	a_pat_sets_seen: assert property (@(posedge clk_i) disable iff (rst_i)
		pat_hit |=> pattern_wake_seen && pme_status)
		else $error("pattern hit not recorded");
	a_pat_d0_inert: assert property (@(posedge clk_i) disable iff (rst_i)
		!asleep |-> !pat_hit)
		else $error("pattern wake in D0");
	a_pme_holds: assert property (@(posedge clk_i) disable iff (rst_i)
		pme_status && !clr_pme |=> pme_status)
		else $error("event status dropped without clear");
	a_d1_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_pwr && wb_sel_i[0] && req_state == 2'h1 && !d1_ok
		|=> power_state_field == $past(power_state_field))
		else $error("unsupported light sleep entered");
	a_d2_gated: assert property (@(posedge clk_i) disable iff (rst_i)
		wr_pwr && wb_sel_i[0] && req_state == 2'h2 && !d2_ok
		|=> power_state_field == $past(power_state_field))
		else $error("unsupported partial sleep entered");
endmodule

// ==== testbench/ppsw_frame_src.sv ====
// Receive byte source standing in for the network side of the wake detector.
// Assumes the bench calls send from its own process, right after a clock edge.
`timescale 1ns/10ps
module ppsw_frame_src
(
	input wire logic clk_i,
	output ppsw_pkg::ppsw_rx_byte_t rx_o,
	output logic addr_pass_o
);
	// ==========================================================
	// Frame driver
	initial
	begin
		rx_o = '0;
		addr_pass_o = 1'b0;
	end
	// Idle data keeps changing so a stale byte is never taken for a real one.
	// Two idle cycles follow each byte because the pattern engine needs them.
	task automatic send(input logic [7:0] f[$], input logic pass);
		int i;
		for (i = 0; i < f.size(); i++)
		begin
			@(posedge clk_i);
			rx_o <= {1'b1, i == 0, i == f.size() - 1, f[i]};
			addr_pass_o <= (i == f.size() - 1) ? pass : ~pass;
			@(posedge clk_i);
			rx_o <= {3'b000, ~f[i]};
			addr_pass_o <= ~pass;
			@(posedge clk_i);
			rx_o <= {3'b000, f[i] ^ 8'h5a};
		end
	endtask
endmodule

// ==== testbench/pci_power_state_wake_logic_test.sv ====
// Self-checking bench for the power-state and wake block.
// Assumes a Wishbone slave that answers one cycle after a request.
`timescale 1ns/10ps
`include "ppsw_regs.svh"
module pci_power_state_wake_logic_test;
	logic clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [3:0] sel = 4'hf;
	logic [31:0] wdat = 32'h0;
	logic [31:0] dat_o;
	logic [31:0] rdat;
	logic ack;
	logic [15:0] cfg_word = 16'h0000;
	logic magic = 1'b0;
	logic link = 1'b0;
	logic pass;
	logic pin_n;
	logic cfg_done;
	logic [31:0] crc;
	ppsw_pkg::ppsw_rx_byte_t rx;
	ppsw_pkg::ppsw_access_t acc;
	int err_total = 0;
	int n_tests = 0;
	int seed = 2244;
	int s;
	int i;
	logic [7:0] f[$];
	logic [7:0] g[$];
	logic [7:0] pat[$];

	always #4 clk_i = ~clk_i;

	ppsw_top u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(dat_o),
		.wb_ack_o(ack), .eeprom_config_word_i(cfg_word), .rx_i(rx), .rx_addr_pass_i(pass),
		.magic_frame_i(magic), .link_change_i(link), .access_o(acc),
		.wake_event_out_n_o(pin_n), .config_initialised_o(cfg_done));
	ppsw_frame_src u_src (.clk_i(clk_i), .rx_o(rx), .addr_pass_o(pass));

	// ==========================================================
	// Shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic results();
		$display("compares %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask

	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		for (k = 0; k < 16; k++)
		begin
			@(posedge clk_i);
			if (ack === 1'b1)
				break;
		end
		if (k == 16)
		begin
			err_total++;
			results();
		end
		rdat = dat_o;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic expect_pin(input logic v);
		int k;
		for (k = 0; k < 12 && pin_n !== v; k++)
			@(posedge clk_i);
		check({31'h0, pin_n}, {31'h0, v});
		if (pin_n !== v)
			results();
	endtask

	task automatic stays_high();
		repeat (8) @(posedge clk_i);
		check({31'h0, pin_n}, 32'h1);
	endtask

	function automatic logic [31:0] crc_of(input logic [7:0] q[$]);
		logic [31:0] c;
		c = `PPSW_CRC_INIT;
		foreach (q[j])
		begin
			c = c ^ {24'h0, q[j]};
			repeat (8) c = c[0] ? (c >> 1) ^ `PPSW_CRC_POLY : c >> 1;
		end
		return ~c;
	endfunction

	// ==========================================================
	// Main sequence
	initial
	begin
		repeat (3) @(posedge clk_i);
		rst_i <= 1'b0;
		repeat (2) @(posedge clk_i);
		check({28'h0, acc}, 32'h2);
		check({31'h0, pin_n}, 32'h1);
		bus(1'b1, `PPSW_ADR_CMD, 32'h7);
		check({28'h0, acc}, 32'hf);
		check({31'h0, cfg_done}, 32'h1);
		bus(1'b0, `PPSW_ADR_STATUS, 32'h0);
		check(rdat, 32'h100);
		bus(1'b0, 8'h1c, 32'h0);
		check(rdat, 32'h0);
		bus(1'b1, `PPSW_ADR_WAKE_CTRL, 32'h7);
		bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h100);
		link <= 1'b1;
		magic <= 1'b1;
		@(posedge clk_i);
		link <= 1'b0;
		magic <= 1'b0;
		stays_high();
		bus(1'b1, `PPSW_ADR_WAKE_CTRL, 32'h71);
		bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h8100);
		for (s = 1; s < 3; s++)
		begin
			cfg_word <= 16'($random(seed)) & ~(16'h1 << (8 + s));
			@(posedge clk_i);
			bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h100 | s);
			bus(1'b0, `PPSW_ADR_POWER_CTRL, 32'h0);
			check(rdat, 32'h100);
			cfg_word <= cfg_word | (16'h1 << (8 + s));
			@(posedge clk_i);
			bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h100 | s);
			check({28'h0, acc}, 32'h2);
			magic <= 1'b1;
			@(posedge clk_i);
			magic <= 1'b0;
			stays_high();
			link <= 1'b1;
			@(posedge clk_i);
			link <= 1'b0;
			expect_pin(1'b0);
			bus(1'b1, `PPSW_ADR_WAKE_CTRL, 32'h71);
			bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h8100 | s);
			expect_pin(1'b1);
			bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h100);
			check({28'h0, acc}, 32'hf);
		end
		bus(1'b1, `PPSW_ADR_PAT_CLEAR, 32'h0);
		for (i = 0; i < 8; i++)
			f.push_back(8'($random(seed)));
		g = f[2:4];
		crc = crc_of(g);
		pat = {8'h02, 8'h03, `PPSW_PAT_END, crc[7:0], crc[15:8], crc[23:16], crc[31:24]};
		foreach (pat[j])
			bus(1'b1, `PPSW_ADR_PATTERN, {24'h0, pat[j]});
		bus(1'b0, `PPSW_ADR_STATUS, 32'h0);
		check(rdat, 32'h100 | pat.size());
		bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h103);
		bus(1'b0, `PPSW_ADR_CMD, 32'h0);
		check(rdat, 32'h0);
		bus(1'b0, `PPSW_ADR_POWER_CTRL, 32'h0);
		check(rdat, 32'h3);
		check({28'h0, acc}, 32'h2);
		bus(1'b1, `PPSW_ADR_WAKE_CTRL, 32'h4);
		bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h103);
		u_src.send(f, 1'b0);
		stays_high();
		g = f[0:3];
		u_src.send(g, 1'b1);
		stays_high();
		u_src.send(f, 1'b1);
		expect_pin(1'b0);
		bus(1'b0, `PPSW_ADR_WAKE_CTRL, 32'h0);
		check(rdat, 32'h44);
		bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h003);
		expect_pin(1'b1);
		bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h0);
		check({28'h0, acc}, 32'h2);
		check({31'h0, cfg_done}, 32'h0);
		bus(1'b1, `PPSW_ADR_WAKE_CTRL, 32'h74);
		bus(1'b1, `PPSW_ADR_POWER_CTRL, 32'h100);
		u_src.send(f, 1'b1);
		stays_high();
		bus(1'b0, `PPSW_ADR_WAKE_CTRL, 32'h0);
		check(rdat, 32'h4);
		results();
	end
endmodule
